// File: common/pipe_xfer_pkg.sv
// types and constants shared by the service pipe transfer logic
package pipe_xfer_pkg;

    localparam int NPIPE = 8;
    localparam int PIPE_W = 3;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 8;
    localparam int REG_W = 16;

    localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_CFG0 = 8'h08;

    localparam int CTRL_ADV_CONN_BIT = 0;
    localparam int STATUS_CONN_BIT = 8;
    localparam int STATUS_BUSY_BIT = 9;
    localparam int CCCD_NOTIFY_BIT = 0;
    localparam int CCCD_INDICATE_BIT = 1;

    localparam logic CTRL_ADV_CONN_RST = 1'b0;

    typedef enum logic [1:0] {
        ACK_NONE = 2'h0,
        ACK_HOST = 2'h1,
        ACK_AUTO = 2'h2
    } ack_mode_t;

    // register layout of one pipe entry: [5] bcast [4] remote [3] rx [2:1] ack [0] req
    typedef struct packed {
        logic bcast;
        logic remote;
        logic rx;
        ack_mode_t ack;
        logic req;
    } pipe_cfg_t;

    localparam pipe_cfg_t CFG_RST = 6'h00;

    typedef enum logic [1:0] {
        CMD_NONE = 2'h0,
        CMD_SEND = 2'h1,
        CMD_HOST_ACK = 2'h2,
        CMD_REQUEST = 2'h3
    } host_op_t;

    typedef enum logic [3:0] {
        PO_NONE = 4'h0,
        PO_NOTIFY = 4'h1,
        PO_INDICATE = 4'h2,
        PO_WRITE_CMD = 4'h3,
        PO_WRITE_REQ = 4'h4,
        PO_READ_REQ = 4'h5,
        PO_WRITE_RSP = 4'h6,
        PO_CONFIRM = 4'h7,
        PO_ADV_CONN = 4'h8,
        PO_ADV_NONCONN = 4'h9
    } peer_out_op_t;

    typedef enum logic [3:0] {
        PI_NONE = 4'h0,
        PI_WRITE_CMD = 4'h1,
        PI_WRITE_REQ = 4'h2,
        PI_NOTIFY = 4'h3,
        PI_INDICATE = 4'h4,
        PI_READ_RSP = 4'h5,
        PI_CONFIRM = 4'h6,
        PI_WRITE_RSP = 4'h7,
        PI_CCCD_WRITE = 4'h8,
        PI_ERROR = 4'h9
    } peer_in_op_t;

    typedef enum logic [2:0] {
        EV_NONE = 3'h0,
        EV_PEER_ACK = 3'h1,
        EV_PIPE_AVAIL = 3'h2,
        EV_LINK_LOST = 3'h3,
        EV_PIPE_FAULT = 3'h4,
        EV_INBOUND = 3'h5
    } evt_code_t;

    localparam logic [DATA_W-1:0] FAULT_CLOSED = 8'h01;
    localparam logic [DATA_W-1:0] FAULT_BAD_CFG = 8'h02;
    localparam logic [DATA_W-1:0] FAULT_PEER = 8'h03;
    localparam logic [DATA_W-1:0] FAULT_NO_PENDING = 8'h04;

    typedef struct packed {
        logic valid;
        host_op_t op;
        logic [PIPE_W-1:0] pipe;
        logic [DATA_W-1:0] data;
    } host_cmd_t;

    typedef struct packed {
        logic valid;
        evt_code_t code;
        logic [PIPE_W-1:0] pipe;
        logic [DATA_W-1:0] data;
        logic [NPIPE-1:0] bitmap;
    } host_evt_t;

    typedef struct packed {
        logic valid;
        peer_out_op_t op;
        logic [PIPE_W-1:0] pipe;
        logic [DATA_W-1:0] data;
    } peer_out_t;

    typedef struct packed {
        logic valid;
        peer_in_op_t op;
        logic [PIPE_W-1:0] pipe;
        logic [DATA_W-1:0] data;
    } peer_in_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [ADDR_W-1:0] addr;
        logic [REG_W-1:0] wdata;
    } reg_req_t;

endpackage

// File: logic/service_pipe_transfer_logic.sv
// per-pipe transfer engine between host command port and peer link
//
// Operation
// (R1) move data only on open pipes while connected; broadcast pipes send with no open or link check
// (R2) peer acknowledgment raises peer ack event
// (R3) local unacked transmit sends notification
// (R4) local acked transmit indicates, confirm gives ack
// (R5) remote unacked transmit writes without response
// (R6) remote acked transmit writes, response gives ack
// (R7) broadcast pipe data goes into advertising
// (R8) host avoids acked then unacked remote sends
// (R9) local transmit pipes open only by peer
// (R10) notify bit opens, indicate bit opens/closes
// (R11) peer-opened pipe appears in open bitmap
// (R12) connection loss reports link lost event
// (R13) transfer failure reports pipe fault event
// (R14) peer data reaches host as inbound event
// (R15) host acks each host-ack inbound event
// (R16) auto-ack receive pipes acknowledge without host
// (R17) read request only on request-enabled pipes
// (R18) host ack on local pipe sends write response
// (R19) local auto-ack answers write, still reports payload
// (R20) remote unacked receive delivers each notification
// (R21) host ack on remote pipe sends confirmation
// (R22) remote auto-ack confirms indication, reports value
// (R23) request pipe reads peer, reports returned data
// (R24) static per-pipe entry selects peer operation
`timescale 1ns/100ps

module service_pipe_transfer_logic
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // register port
    input wire pipe_xfer_pkg::reg_req_t reg_req,
    output logic [pipe_xfer_pkg::REG_W-1:0] reg_rdata,
    // host command interface
    input wire pipe_xfer_pkg::host_cmd_t host_cmd,
    output logic host_cmd_taken,
    output pipe_xfer_pkg::host_evt_t host_evt,
    // peer link
    input wire logic link_up,
    input wire pipe_xfer_pkg::peer_in_t peer_in,
    output pipe_xfer_pkg::peer_out_t peer_out
);
    import pipe_xfer_pkg::*;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WAIT_ACK,
        ST_WAIT_READ
    } state_t;

    typedef struct packed {
        state_t state;
        pipe_cfg_t [NPIPE-1:0] cfg;
        logic [NPIPE-1:0] cccd;
        logic [NPIPE-1:0] pend;
        logic [NPIPE-1:0] rep;
        logic conn;
        logic adv_conn;
        logic [PIPE_W-1:0] wait_pipe;
        logic cmd_taken;
        host_evt_t evt;
        peer_out_t pdu;
        logic [REG_W-1:0] rdata;
    } core_t;

    core_t s_q;
    core_t s_d;
    logic [NPIPE-1:0] open_now;
    logic lost;
    logic cfg_hit;
    logic [PIPE_W-1:0] cfg_idx;
    pipe_cfg_t pc;
    pipe_cfg_t hc;

    // decode of the per-pipe entry window, shared by reads and writes
    function automatic logic cfg_sel(input logic [ADDR_W-1:0] a, output logic [PIPE_W-1:0] idx);
        logic [ADDR_W-1:0] off;
        off = a - ADDR_CFG0;
        idx = off[2 +: PIPE_W];
        cfg_sel = (a >= ADDR_CFG0) && (off[1:0] == 2'h0) && (off[ADDR_W-1:2] < ADDR_W'(NPIPE));
    endfunction

    // remote and receive pipes count open once connected; service discovery sits elsewhere
    function automatic logic [NPIPE-1:0] open_map(input core_t q);
        logic [NPIPE-1:0] m;
        m = '0;
        for (int i = 0; i < NPIPE; i++)
        begin
            if (!q.cfg[i].bcast && q.conn)
            begin
                if (!q.cfg[i].remote && !q.cfg[i].rx)
                begin
                    m[i] = q.cccd[i]; // R9 R11
                end
                else
                begin
                    m[i] = 1'b1;
                end
            end
        end
        open_map = m;
    endfunction

    function automatic host_evt_t mk_evt(input evt_code_t c, input logic [PIPE_W-1:0] p,
                                         input logic [DATA_W-1:0] d, input logic [NPIPE-1:0] b);
        mk_evt.valid = 1'b1;
        mk_evt.code = c;
        mk_evt.pipe = p;
        mk_evt.data = d;
        mk_evt.bitmap = b;
    endfunction

    function automatic peer_out_t mk_pdu(input peer_out_op_t o, input logic [PIPE_W-1:0] p,
                                         input logic [DATA_W-1:0] d);
        mk_pdu.valid = 1'b1;
        mk_pdu.op = o;
        mk_pdu.pipe = p;
        mk_pdu.data = d;
    endfunction

    always_comb
    begin
        s_d = s_q;
        s_d.evt.valid = 1'b0;
        s_d.pdu.valid = 1'b0;
        s_d.cmd_taken = 1'b0;
        s_d.conn = link_up;
        open_now = open_map(s_q);
        lost = s_q.conn && !link_up;
        pc = s_q.cfg[peer_in.pipe];
        hc = s_q.cfg[host_cmd.pipe];
        cfg_hit = cfg_sel(reg_req.addr, cfg_idx);

        if (lost)
        begin
            // the link is gone: any pending transfer dies with it
            s_d.evt = mk_evt(EV_LINK_LOST, s_q.wait_pipe, 8'h00, '0); // R12
            s_d.state = ST_IDLE;
            s_d.cccd = '0;
            s_d.pend = '0;
        end
        else if (peer_in.valid)
        begin
            case (peer_in.op)
                PI_WRITE_CMD, PI_WRITE_REQ, PI_NOTIFY, PI_INDICATE:
                begin
                    // receive errors are never reported; mismatched traffic is dropped
                    if (open_now[peer_in.pipe] && pc.rx && !pc.req // R1 R24
                        && (pc.remote == (peer_in.op == PI_NOTIFY || peer_in.op == PI_INDICATE))
                        && ((pc.ack == ACK_NONE) == (peer_in.op == PI_WRITE_CMD || peer_in.op == PI_NOTIFY)))
                    begin
                        s_d.evt = mk_evt(EV_INBOUND, peer_in.pipe, peer_in.data, '0); // R14 R20
                        if (pc.ack == ACK_AUTO)
                        begin
                            s_d.pdu = mk_pdu(pc.remote ? PO_CONFIRM : PO_WRITE_RSP, // R16 R19 R22
                                             peer_in.pipe, 8'h00);
                        end
                        else if (pc.ack == ACK_HOST)
                        begin
                            s_d.pend[peer_in.pipe] = 1'b1; // R15
                        end
                    end
                end
                PI_CCCD_WRITE:
                begin
                    if (!pc.bcast && !pc.remote && !pc.rx)
                    begin
                        if (pc.ack == ACK_NONE)
                        begin
                            s_d.cccd[peer_in.pipe] = peer_in.data[CCCD_NOTIFY_BIT]; // R10
                        end
                        else
                        begin
                            s_d.cccd[peer_in.pipe] = peer_in.data[CCCD_INDICATE_BIT]; // R10
                        end
                    end
                end
                PI_CONFIRM, PI_WRITE_RSP:
                begin
                    if (s_q.state == ST_WAIT_ACK && peer_in.pipe == s_q.wait_pipe
                        && s_q.cfg[s_q.wait_pipe].remote == (peer_in.op == PI_WRITE_RSP))
                    begin
                        s_d.evt = mk_evt(EV_PEER_ACK, s_q.wait_pipe, 8'h00, '0); // R2 R4 R6
                        s_d.state = ST_IDLE;
                    end
                end
                PI_READ_RSP:
                begin
                    if (s_q.state == ST_WAIT_READ && peer_in.pipe == s_q.wait_pipe)
                    begin
                        s_d.evt = mk_evt(EV_INBOUND, s_q.wait_pipe, peer_in.data, '0); // R23
                        s_d.state = ST_IDLE;
                    end
                end
                PI_ERROR:
                begin
                    if (s_q.state != ST_IDLE)
                    begin
                        s_d.evt = mk_evt(EV_PIPE_FAULT, s_q.wait_pipe, FAULT_PEER, '0); // R13
                        s_d.state = ST_IDLE;
                    end
                end
                default:
                begin
                end
            endcase
        end
        // peer traffic wins the cycle; the host keeps its command up and retries
        else if (host_cmd.valid && !s_q.cmd_taken && s_q.state == ST_IDLE)
        begin
            s_d.cmd_taken = 1'b1;
            s_d.wait_pipe = host_cmd.pipe;
            case (host_cmd.op)
                CMD_SEND:
                begin
                    if (hc.rx)
                    begin
                        s_d.evt = mk_evt(EV_PIPE_FAULT, host_cmd.pipe, FAULT_BAD_CFG, '0); // R13
                    end
                    else if (hc.bcast)
                    begin
                        s_d.pdu = mk_pdu(s_q.adv_conn ? PO_ADV_CONN : PO_ADV_NONCONN, // R7
                                         host_cmd.pipe, host_cmd.data);
                    end
                    else if (!open_now[host_cmd.pipe])
                    begin
                        s_d.evt = mk_evt(EV_PIPE_FAULT, host_cmd.pipe, FAULT_CLOSED, '0); // R1 R9 R13
                    end
                    else if (hc.ack == ACK_NONE)
                    begin
                        s_d.pdu = mk_pdu(hc.remote ? PO_WRITE_CMD : PO_NOTIFY, // R3 R5 R24
                                         host_cmd.pipe, host_cmd.data);
                    end
                    else
                    begin
                        s_d.pdu = mk_pdu(hc.remote ? PO_WRITE_REQ : PO_INDICATE, // R4 R6 R24
                                         host_cmd.pipe, host_cmd.data);
                        s_d.state = ST_WAIT_ACK;
                    end
                end
                CMD_HOST_ACK:
                begin
                    if (hc.rx && hc.ack == ACK_HOST && s_q.pend[host_cmd.pipe])
                    begin
                        s_d.pdu = mk_pdu(hc.remote ? PO_CONFIRM : PO_WRITE_RSP, // R18 R21
                                         host_cmd.pipe, 8'h00);
                        s_d.pend[host_cmd.pipe] = 1'b0;
                    end
                    else
                    begin
                        s_d.evt = mk_evt(EV_PIPE_FAULT, host_cmd.pipe, FAULT_NO_PENDING, '0);
                    end
                end
                CMD_REQUEST:
                begin
                    if (!(hc.rx && hc.remote && hc.req))
                    begin
                        s_d.evt = mk_evt(EV_PIPE_FAULT, host_cmd.pipe, FAULT_BAD_CFG, '0); // R17
                    end
                    else if (!open_now[host_cmd.pipe])
                    begin
                        s_d.evt = mk_evt(EV_PIPE_FAULT, host_cmd.pipe, FAULT_CLOSED, '0); // R1
                    end
                    else
                    begin
                        s_d.pdu = mk_pdu(PO_READ_REQ, host_cmd.pipe, 8'h00); // R17 R23
                        s_d.state = ST_WAIT_READ;
                    end
                end
                default:
                begin
                    s_d.evt = mk_evt(EV_PIPE_FAULT, host_cmd.pipe, FAULT_BAD_CFG, '0);
                end
            endcase
        end

        // availability is reported in the first cycle free of other events
        if (!s_d.evt.valid && open_now != s_q.rep)
        begin
            s_d.evt = mk_evt(EV_PIPE_AVAIL, '0, 8'h00, open_now); // R11
            s_d.rep = open_now;
        end

        // pipe entries are static: writes are ignored while connected
        if (reg_req.wr)
        begin
            if (reg_req.addr == ADDR_CTRL)
            begin
                s_d.adv_conn = reg_req.wdata[CTRL_ADV_CONN_BIT];
            end
            else if (cfg_hit && !s_q.conn)
            begin
                s_d.cfg[cfg_idx] = reg_req.wdata[$bits(pipe_cfg_t)-1:0]; // R24
            end
        end

        s_d.rdata = '0;
        if (reg_req.rd)
        begin
            if (reg_req.addr == ADDR_CTRL)
            begin
                s_d.rdata[CTRL_ADV_CONN_BIT] = s_q.adv_conn;
            end
            else if (reg_req.addr == ADDR_STATUS)
            begin
                s_d.rdata[NPIPE-1:0] = s_q.rep;
                s_d.rdata[STATUS_CONN_BIT] = s_q.conn;
                s_d.rdata[STATUS_BUSY_BIT] = (s_q.state != ST_IDLE);
            end
            else if (cfg_hit)
            begin
                s_d.rdata[$bits(pipe_cfg_t)-1:0] = s_q.cfg[cfg_idx];
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            s_q <= '0;
            s_q.state <= ST_IDLE;
            s_q.cfg <= {NPIPE{CFG_RST}};
            s_q.adv_conn <= CTRL_ADV_CONN_RST;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign reg_rdata = s_q.rdata;
    assign host_cmd_taken = s_q.cmd_taken;
    assign host_evt = s_q.evt;
    assign peer_out = s_q.pdu;

endmodule

// File: sim/pipe_xfer_chk.sv
// port assertions for the service pipe transfer logic
`timescale 1ns/100ps
module pipe_xfer_chk
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // watched ports
    input wire pipe_xfer_pkg::reg_req_t reg_req,
    input wire logic [pipe_xfer_pkg::REG_W-1:0] reg_rdata,
    input wire pipe_xfer_pkg::host_cmd_t host_cmd,
    input wire logic host_cmd_taken,
    input wire pipe_xfer_pkg::host_evt_t host_evt,
    input wire logic link_up,
    input wire pipe_xfer_pkg::peer_in_t peer_in,
    input wire pipe_xfer_pkg::peer_out_t peer_out
);
    import pipe_xfer_pkg::*;
    logic tx_op;
    logic ev_ok;
    assign tx_op = peer_out.valid && peer_out.op inside {PO_NOTIFY, PO_INDICATE, PO_WRITE_CMD, PO_WRITE_REQ};
    assign ev_ok = host_evt.valid;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    a_rdata_one_cycle: assert property (!$past(reg_req.rd) |-> reg_rdata == '0)
        else $error("read data outside its cycle");
    a_taken_cause: assert property (host_cmd_taken |-> $past(host_cmd.valid) && !$past(host_cmd_taken))
        else $error("command taken without request");
    a_tx_from_send: assert property (tx_op |-> host_cmd_taken && $past(host_cmd.op) == CMD_SEND
        && peer_out.data == $past(host_cmd.data) && peer_out.pipe == $past(host_cmd.pipe))
        else $error("transmit op not from send command");
    a_tx_connected: assert property (tx_op |-> $past(link_up) && link_up)
        else $error("transmit while not connected");
    a_inbound_echo: assert property (ev_ok && host_evt.code == EV_INBOUND |-> $past(peer_in.valid)
        && host_evt.data == $past(peer_in.data) && host_evt.pipe == $past(peer_in.pipe))
        else $error("inbound event does not match peer data");
    a_ack_cause: assert property (ev_ok && host_evt.code == EV_PEER_ACK |-> $past(peer_in.valid)
        && $past(peer_in.op) inside {PI_CONFIRM, PI_WRITE_RSP})
        else $error("peer ack event without peer answer");
    a_wrsp_cause: assert property (peer_out.valid && peer_out.op == PO_WRITE_RSP |->
        (host_cmd_taken && $past(host_cmd.op) == CMD_HOST_ACK)
        || ($past(peer_in.valid) && $past(peer_in.op) == PI_WRITE_REQ))
        else $error("write response without cause");
    a_confirm_cause: assert property (peer_out.valid && peer_out.op == PO_CONFIRM |->
        (host_cmd_taken && $past(host_cmd.op) == CMD_HOST_ACK)
        || ($past(peer_in.valid) && $past(peer_in.op) == PI_INDICATE))
        else $error("confirmation without cause");
    a_read_cause: assert property (peer_out.valid && peer_out.op == PO_READ_REQ |->
        host_cmd_taken && $past(host_cmd.op) == CMD_REQUEST)
        else $error("read request without request command");
    a_lost_when_down: assert property (ev_ok && host_evt.code == EV_LINK_LOST |-> !$past(link_up))
        else $error("link lost event while connected");
endmodule

bind service_pipe_transfer_logic pipe_xfer_chk u_chk (.clk_sys(clk_sys), .rst_n(rst_n), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .host_cmd(host_cmd), .host_cmd_taken(host_cmd_taken), .host_evt(host_evt),
    .link_up(link_up), .peer_in(peer_in), .peer_out(peer_out));

// File: sim/peer_link_model.sv
// behavioural peer radio answering on the link side
`timescale 1ns/100ps
module peer_link_model
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // link side
    input wire logic link_up,
    input wire pipe_xfer_pkg::peer_out_t peer_out,
    output pipe_xfer_pkg::peer_in_t peer_in,
    // bench control
    input wire pipe_xfer_pkg::peer_in_t inj,
    input wire logic [7:0] lat,
    input wire logic err
);
    import pipe_xfer_pkg::*;
    peer_in_t rsp_q;
    logic [7:0] cnt_q;
    logic pend_q;
    always_ff @(posedge clk_sys)
    begin
        // a lost link never answers
        if (!rst_n || !link_up)
            pend_q <= 1'b0;
        else if (peer_out.valid && peer_out.op inside {PO_INDICATE, PO_WRITE_REQ, PO_READ_REQ})
        begin
            pend_q <= 1'b1;
            cnt_q <= lat;
            rsp_q.valid <= 1'b1;
            rsp_q.pipe <= peer_out.pipe;
            rsp_q.data <= 8'hC3;
            rsp_q.op <= err ? PI_ERROR : peer_out.op == PO_INDICATE ? PI_CONFIRM :
                peer_out.op == PO_WRITE_REQ ? PI_WRITE_RSP : PI_READ_RSP;
        end
        else if (pend_q && cnt_q == 8'h00)
            pend_q <= 1'b0;
        else if (pend_q)
            cnt_q <= cnt_q - 8'h01;
    end
    // bench stimulus never overlaps a due answer
    assign peer_in = (pend_q && cnt_q == 8'h00) ? rsp_q : inj;
endmodule

// File: sim/tb_top.sv
// self-checking bench for the service pipe transfer logic
`timescale 1ns/100ps
module tb_top;
    import pipe_xfer_pkg::*;
    localparam logic [5:0] CFG [8] = '{6'h00, 6'h02, 6'h10, 6'h12, 6'h0A, 6'h0C, 6'h1C, 6'h19};
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic link_up = 1'b0;
    logic err = 1'b0;
    logic [7:0] lat = 8'h02;
    reg_req_t reg_req = '0;
    host_cmd_t host_cmd = '0;
    peer_in_t inj = '0;
    peer_in_t peer_in;
    peer_out_t peer_out;
    host_evt_t host_evt;
    logic host_cmd_taken;
    logic [REG_W-1:0] reg_rdata;
    int fail_count = 0;
    int check_count = 0;
    int cycle_count = 0;
    host_evt_t evq[$];
    peer_out_t poq[$];
    always #50 clk_sys = ~clk_sys;
    service_pipe_transfer_logic dut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .host_cmd(host_cmd), .host_cmd_taken(host_cmd_taken),
        .host_evt(host_evt), .link_up(link_up), .peer_in(peer_in), .peer_out(peer_out));
    peer_link_model peer (.clk_sys(clk_sys), .rst_n(rst_n), .link_up(link_up), .peer_out(peer_out),
        .peer_in(peer_in), .inj(inj), .lat(lat), .err(err));
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    always @(posedge clk_sys)
    begin
        cycle_count++;
        if (host_evt.valid === 1'b1)
            evq.push_back(host_evt);
        if (peer_out.valid === 1'b1)
            poq.push_back(peer_out);
        if (cycle_count == 5000)
        begin
            fail_count++;
            tally_and_finish();
        end
    end
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rw(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        reg_req <= '{1'b1, 1'b0, a, d};
        @(posedge clk_sys);
        reg_req <= '0;
    endtask
    task automatic rc(input logic [7:0] a, input logic [15:0] exp);
        @(posedge clk_sys);
        reg_req <= '{1'b0, 1'b1, a, 16'h0000};
        @(posedge clk_sys);
        reg_req <= '0;
        @(posedge clk_sys);
        chk("register", exp, reg_rdata);
    endtask
    task automatic hs(input host_op_t op, input logic [2:0] pipe, input logic [7:0] data);
        int n;
        @(posedge clk_sys);
        host_cmd <= '{1'b1, op, pipe, data};
        for (n = 0; n < 80 && host_cmd_taken !== 1'b1; n++)
            @(posedge clk_sys);
        host_cmd <= '0;
        chk("taken", 16'h0001, {15'h0000, host_cmd_taken});
    endtask
    task automatic ps(input peer_in_op_t op, input logic [2:0] pipe, input logic [7:0] data);
        @(posedge clk_sys);
        inj <= '{1'b1, op, pipe, data};
        @(posedge clk_sys);
        inj <= '0;
    endtask
    task automatic ev(input evt_code_t code, input logic [2:0] pipe, input logic [7:0] data);
        host_evt_t e;
        int n;
        e = '0;
        // availability reports are skipped unless asked for
        for (n = 0; n < 80 && (evq.size() == 0 || (code != EV_PIPE_AVAIL && evq[0].code == EV_PIPE_AVAIL)); n++)
        begin
            if (evq.size() != 0)
                e = evq.pop_front();
            @(posedge clk_sys);
        end
        if (evq.size() != 0)
            e = evq.pop_front();
        if (code inside {EV_PIPE_AVAIL, EV_LINK_LOST})
            e.pipe = pipe;
        if (code inside {EV_PEER_ACK, EV_LINK_LOST})
            e.data = data;
        else if (code == EV_PIPE_AVAIL)
            e.data = e.bitmap;
        chk("event", {2'b00, code, pipe, data}, {2'b00, e.code, e.pipe, e.data});
    endtask
    task automatic po(input peer_out_op_t op, input logic [2:0] pipe, input logic [7:0] data);
        peer_out_t p;
        int n;
        p = '0;
        for (n = 0; n < 80 && poq.size() == 0; n++)
            @(posedge clk_sys);
        if (poq.size() != 0)
            p = poq.pop_front();
        if (op inside {PO_WRITE_RSP, PO_CONFIRM, PO_READ_REQ})
            p.data = data;
        chk("peer op", {1'b0, op, pipe, data}, {1'b0, p.op, p.pipe, p.data});
    endtask
    task automatic t_regs();
        rc(ADDR_STATUS, 16'h0000);
        rc(ADDR_CFG0, 16'h0000);
        rc(8'h40, 16'h0000);
        for (int i = 0; i < NPIPE; i++)
            rw(ADDR_CFG0 + 8'(4 * i), {10'h000, CFG[i]});
        rc(ADDR_CFG0 + 8'h1C, 16'h0019);
        $display("test regs done");
    endtask
    task automatic t_open();
        @(posedge clk_sys);
        link_up <= 1'b1;
        ev(EV_PIPE_AVAIL, 3'h0, 8'hFC);
        rw(ADDR_CFG0, 16'h003F);
        rc(ADDR_CFG0, 16'h0000);
        hs(CMD_SEND, 3'h0, 8'h11);
        ev(EV_PIPE_FAULT, 3'h0, FAULT_CLOSED);
        ps(PI_CCCD_WRITE, 3'h0, 8'h01);
        ev(EV_PIPE_AVAIL, 3'h0, 8'hFD);
        ps(PI_CCCD_WRITE, 3'h1, 8'h02);
        ev(EV_PIPE_AVAIL, 3'h0, 8'hFF);
        rc(ADDR_STATUS, 16'h01FF);
        $display("test open done");
    endtask
    task automatic t_tx();
        hs(CMD_SEND, 3'h0, 8'h21);
        po(PO_NOTIFY, 3'h0, 8'h21);
        hs(CMD_SEND, 3'h1, 8'h22);
        po(PO_INDICATE, 3'h1, 8'h22);
        ev(EV_PEER_ACK, 3'h1, 8'h00);
        // unacked remote goes first so no ack is lost
        hs(CMD_SEND, 3'h2, 8'h23);
        po(PO_WRITE_CMD, 3'h2, 8'h23);
        lat <= 8'd30;
        hs(CMD_SEND, 3'h3, 8'h24);
        po(PO_WRITE_REQ, 3'h3, 8'h24);
        ev(EV_PEER_ACK, 3'h3, 8'h00);
        ps(PI_CCCD_WRITE, 3'h1, 8'h00);
        ev(EV_PIPE_AVAIL, 3'h0, 8'hFD);
        hs(CMD_SEND, 3'h1, 8'h25);
        ev(EV_PIPE_FAULT, 3'h1, FAULT_CLOSED);
        $display("test transmit done");
    endtask
    task automatic t_rx();
        ps(PI_WRITE_REQ, 3'h4, 8'h41);
        ev(EV_INBOUND, 3'h4, 8'h41);
        hs(CMD_HOST_ACK, 3'h4, 8'h00);
        po(PO_WRITE_RSP, 3'h4, 8'h00);
        hs(CMD_HOST_ACK, 3'h4, 8'h00);
        ev(EV_PIPE_FAULT, 3'h4, FAULT_NO_PENDING);
        @(posedge clk_sys);
        inj <= '{1'b1, PI_WRITE_REQ, 3'h5, 8'h51};
        @(posedge clk_sys);
        inj <= '{1'b1, PI_INDICATE, 3'h6, 8'h61};
        @(posedge clk_sys);
        inj <= '0;
        ev(EV_INBOUND, 3'h5, 8'h51);
        ev(EV_INBOUND, 3'h6, 8'h61);
        po(PO_WRITE_RSP, 3'h5, 8'h00);
        po(PO_CONFIRM, 3'h6, 8'h00);
        hs(CMD_REQUEST, 3'h4, 8'h00);
        ev(EV_PIPE_FAULT, 3'h4, FAULT_BAD_CFG);
        hs(CMD_REQUEST, 3'h7, 8'h00);
        po(PO_READ_REQ, 3'h7, 8'h00);
        ev(EV_INBOUND, 3'h7, 8'hC3);
        $display("test receive done");
    endtask
    task automatic t_fault_loss();
        err <= 1'b1;
        hs(CMD_SEND, 3'h3, 8'h33);
        po(PO_WRITE_REQ, 3'h3, 8'h33);
        ev(EV_PIPE_FAULT, 3'h3, FAULT_PEER);
        err <= 1'b0;
        hs(CMD_SEND, 3'h3, 8'h34);
        po(PO_WRITE_REQ, 3'h3, 8'h34);
        link_up <= 1'b0;
        ev(EV_LINK_LOST, 3'h0, 8'h00);
        repeat (10) @(posedge clk_sys);
        evq.delete();
        rw(ADDR_CFG0, 16'h0020);
        rw(ADDR_CFG0 + 8'h10, 16'h001A);
        rw(ADDR_CFG0 + 8'h14, 16'h0018);
        hs(CMD_SEND, 3'h0, 8'h71);
        po(PO_ADV_NONCONN, 3'h0, 8'h71);
        rw(ADDR_CTRL, 16'h0001);
        hs(CMD_SEND, 3'h0, 8'h72);
        po(PO_ADV_CONN, 3'h0, 8'h72);
        link_up <= 1'b1;
        ev(EV_PIPE_AVAIL, 3'h0, 8'hFC);
        rc(ADDR_STATUS, 16'h01FC);
        ps(PI_NOTIFY, 3'h5, 8'h55);
        ev(EV_INBOUND, 3'h5, 8'h55);
        ps(PI_INDICATE, 3'h4, 8'h44);
        ev(EV_INBOUND, 3'h4, 8'h44);
        hs(CMD_HOST_ACK, 3'h4, 8'h00);
        po(PO_CONFIRM, 3'h4, 8'h00);
        $display("test fault and loss done");
    endtask
    initial
    begin
        repeat (10) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_regs();
        t_open();
        t_tx();
        t_rx();
        t_fault_loss();
        tally_and_finish();
    end
endmodule
